// file: rtl/gic_map.vh
`ifndef GIC_MAP_VH
`define GIC_MAP_VH

// ----------------------------------------------------------------------
// operation codes as issued by decode
// ----------------------------------------------------------------------
`define GIC_OP_ISUB      8'h0D
`define GIC_OP_ISUBI     8'h20
`define GIC_OP_INEQI     8'h03
`define GIC_OP_INEQ      8'h27
`define GIC_OP_IZERO     8'h2E
`define GIC_OP_INONZERO  8'h2F
`define GIC_OP_JMPF      8'hB4
`define GIC_OP_JMPT      8'hB0
`define GIC_OP_JMPI      8'hB2

// ----------------------------------------------------------------------
// field positions, reset values and latencies
// ----------------------------------------------------------------------
`define GIC_GUARD_BIT    0
`define GIC_COND_BIT     0
`define GIC_IMM_MSB      6
`define GIC_RESULT_RST   32'h00000000
`define GIC_PC_RST       32'h00000000
`define GIC_ALU_LAT      1
`define GIC_JMP_LAT      3

`endif

// file: rtl/gic_delay.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// fixed-depth pipeline for the jump redirect
// ----------------------------------------------------------------------
module gic_delay (
  clock,
  sys_rst,
  in_valid,
  in_target,
  out_valid,
  out_target
);
  input         clock;
  input         sys_rst;
  input         in_valid;
  input  [31:0] in_target;
  output        out_valid;
  output [31:0] out_target;
  wire          clock;
  wire          sys_rst;
  wire          in_valid;
  wire   [31:0] in_target;
  wire          out_valid;
  wire   [31:0] out_target;

  reg    [1:0]  valid_reg;
  reg    [31:0] target_reg [0:1];

  // two stages here plus the register in the caller give three cycles
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      valid_reg     <= 2'h0;
      target_reg[0] <= 32'h00000000;
      target_reg[1] <= 32'h00000000;
    end else begin
      valid_reg     <= {valid_reg[0], in_valid};
      target_reg[0] <= in_target;
      target_reg[1] <= target_reg[0];
    end
  end

  assign out_valid  = valid_reg[1];
  assign out_target = target_reg[1];
endmodule // gic_delay

// file: rtl/gic_exec.v
`timescale 1ns/1ps
`include "gic_map.vh"

module gic_exec (
  clock,
  sys_rst,
  issue_valid,
  issue_opcode,
  guard_present,
  guard_value,
  first_source,
  second_source,
  issue_imm,
  issue_dest,
  result_valid,
  result_write,
  result_dest,
  result_data,
  redirect_valid,
  redirect_pc
);
  input         clock;
  input         sys_rst;
  input         issue_valid;
  input  [7:0]  issue_opcode;
  input         guard_present;
  input  [31:0] guard_value;
  input  [31:0] first_source;
  input  [31:0] second_source;
  input  [31:0] issue_imm;
  input  [6:0]  issue_dest;
  output        result_valid;
  output        result_write;
  output [6:0]  result_dest;
  output [31:0] result_data;
  output        redirect_valid;
  output [31:0] redirect_pc;
  wire          clock;
  wire          sys_rst;
  wire          issue_valid;
  wire   [7:0]  issue_opcode;
  wire          guard_present;
  wire   [31:0] guard_value;
  wire   [31:0] first_source;
  wire   [31:0] second_source;
  wire   [31:0] issue_imm;
  wire   [6:0]  issue_dest;
  wire          result_valid;
  wire          result_write;
  wire   [6:0]  result_dest;
  wire   [31:0] result_data;
  wire          redirect_valid;
  wire   [31:0] redirect_pc;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // sign-extend a 7-bit modifier; also used for the zero-extended form
  function [31:0] ext7;
    input [6:0] v;
    input       signed_form;
    begin
      ext7 = {{25{signed_form & v[`GIC_IMM_MSB]}}, v};
    end
  endfunction

  // not-equal flag widened to a full register value
  function [31:0] ne_word;
    input [31:0] x;
    input [31:0] y;
    begin
      ne_word = {31'h0, (x != y)};
    end
  endfunction

  // select: zero when the test holds, otherwise pass the value through
  function [31:0] zero_or;
    input        zero_it;
    input [31:0] v;
    begin
      zero_or = zero_it ? 32'h00000000 : v;
    end
  endfunction

  // only bit 0 of the guard is looked at; upper bits are don't-care
  // absent guard behaves as a true guard
  wire guard_ok;
  assign guard_ok = ~guard_present | guard_value[`GIC_GUARD_BIT];

  // ----------------------------------------------------------------------
  // alu result selection
  // ----------------------------------------------------------------------
  reg        is_alu;
  reg [31:0] alu_next;
  // unknown opcodes leave is_alu low, so no result pulse appears
  always @* begin
    is_alu   = 1'h1;
    alu_next = 32'h00000000;
    case (issue_opcode)
      `GIC_OP_INEQ:
        alu_next = ne_word(first_source, second_source);
      `GIC_OP_INEQI:
        alu_next = ne_word(first_source, ext7(issue_imm[6:0], 1'h1));
      `GIC_OP_IZERO:
        alu_next = zero_or(first_source == 32'h00000000, second_source);
      `GIC_OP_INONZERO:
        alu_next = zero_or(first_source != 32'h00000000, second_source);
      // signed and unsigned give the same bits, so no flags are kept
      // wrap-around subtract
      `GIC_OP_ISUB:
        alu_next = first_source - second_source;
      // zero extension keeps 0 to 127 in range without a check
      // unsigned immediate subtract
      `GIC_OP_ISUBI:
        alu_next = first_source - ext7(issue_imm[6:0], 1'h0);
      default:
        is_alu = 1'h0;
    endcase
  end

  // ----------------------------------------------------------------------
  // jump decision
  // ----------------------------------------------------------------------
  // condition and target are settled in the issue cycle
  reg        take_jump;
  reg [31:0] jump_target;
  always @* begin
    take_jump   = 1'h0;
    // conditional jumps take the second source as their target; JMPI takes the immediate
    jump_target = second_source;
    case (issue_opcode)
      `GIC_OP_JMPF:
        take_jump = ~first_source[`GIC_COND_BIT];
      // jump on true, the same condition bit without inversion
      `GIC_OP_JMPT:
        take_jump = first_source[`GIC_COND_BIT];
      `GIC_OP_JMPI: begin
        take_jump   = 1'h1;
        jump_target = issue_imm;
      end
      default:
        take_jump = 1'h0;
    endcase
  end

  // ----------------------------------------------------------------------
  // result stage, one cycle after issue
  // ----------------------------------------------------------------------
  reg        valid_reg;
  reg        write_reg;
  reg [6:0]  dest_reg;
  reg [31:0] data_reg;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      valid_reg <= 1'h0;
      write_reg <= 1'h0;
      dest_reg  <= 7'h00;
      data_reg  <= `GIC_RESULT_RST;
    end else begin
      valid_reg <= issue_valid & is_alu;
      write_reg <= issue_valid & is_alu & guard_ok;
      dest_reg  <= issue_dest;
      // computed even on a false guard; write-back ignores it then
      data_reg  <= alu_next;
    end
  end

  assign result_valid = valid_reg;
  assign result_write = write_reg;
  assign result_dest  = dest_reg;
  assign result_data  = data_reg;

  // ----------------------------------------------------------------------
  // jump stage, first of the three redirect cycles
  // ----------------------------------------------------------------------
  reg        jump_reg;
  reg [31:0] target_reg;
  // target is latched on every issue; only the valid bit carries meaning
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      jump_reg   <= 1'h0;
      target_reg <= `GIC_PC_RST;
    end else begin
      jump_reg   <= issue_valid & take_jump & guard_ok;
      target_reg <= jump_target;
    end
  end

  // ----------------------------------------------------------------------
  // redirect pipeline, three cycles after issue
  // ----------------------------------------------------------------------
  // redirect_pc takes a new target every cycle; read it only with redirect_valid
  // branch delay of three
  gic_delay u_delay (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .in_valid   (jump_reg),
    .in_target  (target_reg),
    .out_valid  (redirect_valid),
    .out_target (redirect_pc)
  );
endmodule // gic_exec

// file: bench/gic_exec_properties.sv
`timescale 1ns/1ps
`include "gic_map.vh"
module gic_exec_checker (
  input logic clock, sys_rst, issue_valid, guard_present, result_valid,
  input logic result_write, redirect_valid,
  input logic [7:0] issue_opcode,
  input logic [31:0] guard_value, first_source, second_source, issue_imm,
  input logic [31:0] result_data, redirect_pc
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // opcode only counts while issued; go means the guard lets it act
  wire [7:0] op = issue_valid ? issue_opcode : 8'h00;
  wire go = !guard_present | guard_value[0];
  wire [31:0] a = first_source, b = second_source, m = issue_imm;
  wire [31:0] sx = {{25{m[6]}}, m[6:0]}, ux = {25'h0, m[6:0]};
  sequence s_redir;
    ##3 redirect_valid;
  endsequence
  sequence s_no_redir;
    ##3 !redirect_valid;
  endsequence
  zero_sel_a: assert property (
    op == `GIC_OP_IZERO |=> result_data == ($past(a) == 0 ? 0 : $past(b)))
    else $error("izero result");
  guard_jump_a: assert property (
    (op == `GIC_OP_JMPF || op == `GIC_OP_JMPT || op == `GIC_OP_JMPI) &&
    !go |-> s_no_redir) else $error("jump despite false guard");
  ineq_result_a: assert property (
    op == `GIC_OP_INEQ |=> result_data == ($past(a) != $past(b)))
    else $error("ineq result");
  guard_off_a: assert property (
    op == `GIC_OP_ISUB && !go |=> result_valid && !result_write)
    else $error("guard ignored");
  ineqi_result_a: assert property (
    op == `GIC_OP_INEQI |=> result_data == ($past(a) != $past(sx)))
    else $error("ineqi result");
  nonzero_sel_a: assert property (
    op == `GIC_OP_INONZERO |=> result_data == ($past(a) ? 0 : $past(b)))
    else $error("inonzero result");
  sub_wrap_a: assert property (
    op == `GIC_OP_ISUB |=> result_data == $past(a) - $past(b))
    else $error("isub result");
  subi_imm_a: assert property (
    op == `GIC_OP_ISUBI |=> result_data == $past(a) - $past(ux))
    else $error("isubi result");
  jmpf_taken_a: assert property (
    op == `GIC_OP_JMPF && go && !a[0] |->
    s_redir ##0 redirect_pc == $past(b, 3)) else $error("jmpf target");
  jmpi_taken_a: assert property (
    op == `GIC_OP_JMPI && go |->
    s_redir ##0 redirect_pc == $past(m, 3)) else $error("jmpi target");
endmodule // gic_exec_checker

bind gic_exec gic_exec_checker u_chk (.*);

// file: bench/gic_core_model.sv
`timescale 1ns/1ps
// write-back side; a false guard must leave the file untouched
module gic_core_model (
  input logic clock, result_write, redirect_valid,
  input logic [6:0] result_dest,
  input logic [31:0] result_data, redirect_pc
);
  logic [31:0] regs_reg [0:127];
  logic [31:0] pc_reg;
  always @(posedge clock) begin
    if (result_write) regs_reg[result_dest] <= result_data;
    if (redirect_valid) pc_reg <= redirect_pc;
  end
endmodule // gic_core_model

// file: bench/tb_gic_exec.sv
`timescale 1ns/1ps
`include "gic_map.vh"
module tb_gic_exec;
  logic clock = 0, sys_rst = 1, issue_valid = 0, guard_present = 0;
  logic result_valid, result_write, redirect_valid;
  logic [7:0] issue_opcode = 0, o;
  logic [6:0] issue_dest = 0, result_dest;
  logic [31:0] guard_value = 0, first_source = 0, second_source = 0;
  logic [31:0] issue_imm = 0, result_data, redirect_pc, r, a, m;
  logic [73:0] pipe [0:2];
  logic [71:0] ops = 72'h27032E2F0D20B4B0B2; // the nine opcodes
  int mismatches = 0, compares = 0;
  // outputs masked to what they are meant to carry
  wire [40:0] ga = {result_valid, result_valid & result_write,
    result_valid ? result_dest : 7'h00,
    result_valid & result_write ? result_data : 32'h0};
  wire [32:0] gj = {redirect_valid, redirect_valid ? redirect_pc : 32'h0};
  gic_exec u_dut (.*);
  gic_core_model u_core (.*);
  initial begin
    forever #5 clock = ~clock;
  end
  // {valid, write, dest, data, redirect, target} for one issue
  function automatic logic [73:0] want(logic v, g, logic [7:0] o,
    logic [31:0] a, b, m, logic [6:0] d);
    logic [31:0] q;
    logic al, j;
    q = 0; j = 0; al = v & !o[7];
    case (o)
      `GIC_OP_INEQ: q = a != b;
      `GIC_OP_INEQI: q = a != {{25{m[6]}}, m[6:0]};
      `GIC_OP_IZERO: q = a == 0 ? 0 : b;
      `GIC_OP_INONZERO: q = a != 0 ? 0 : b;
      `GIC_OP_ISUB: q = a - b;
      `GIC_OP_ISUBI: q = a - m[6:0];
      `GIC_OP_JMPT: j = a[0];
      `GIC_OP_JMPF: j = !a[0];
      `GIC_OP_JMPI: j = 1;
      default: al = 0;
    endcase
    j = j & v & g;
    return {al, al & g, al ? d : 7'h00, al & g ? q : 32'h0, j,
      j ? (o == `GIC_OP_JMPI ? m : b) : 32'h0};
  endfunction
  // stage 0 holds the op sampled at the last edge: alu read there, jumps at 2
  always @(posedge clock) begin
    pipe[0] <= sys_rst ? 74'h0 : want(issue_valid, !guard_present |
      guard_value[0], issue_opcode, first_source, second_source,
      issue_imm, issue_dest);
    for (int i = 1; i < 3; i++) pipe[i] <= sys_rst ? 74'h0 : pipe[i - 1];
  end
  task automatic check(string n, logic [40:0] e, g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // outputs are settled by the falling edge
  always @(negedge clock) begin
    if (!sys_rst) begin
      check("alu", pipe[0][73:33], ga);
      check("jump", pipe[2][32:0], gj);
    end
  end
  task automatic issue(logic [7:0] o, logic p, logic [31:0] g, a, b, m);
    issue_valid <= 1; issue_opcode <= o; guard_present <= p;
    guard_value <= g; first_source <= a; second_source <= b;
    issue_imm <= m; issue_dest <= r[6:0];
    @(posedge clock);
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog, about two and a half times the expected run
  initial begin
    #12000;
    mismatches++;
    give_verdict;
  end
  initial begin
    r = $urandom(33231);
    repeat (5) @(posedge clock);
    sys_rst <= 0;
    issue(`GIC_OP_ISUB, 0, 0, 3, 4, 0);
    issue(`GIC_OP_JMPI, 0, 0, 0, 0, 32'h330);
    issue(`GIC_OP_INEQI, 1, 1, 32'hFFFFFFC0, 0, 32'h40);
    issue(`GIC_OP_JMPF, 1, 0, 0, 32'h8000, 0);
    issue(`GIC_OP_ISUBI, 1, 0, 32'hF11, 0, 32'h7F);
    issue_valid <= 0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    // all corners share one dest: the false-guard subtract must keep 0
    check("kept dest", 41'h0, u_core.regs_reg[r[6:0]]);
    check("pc", 41'h330, u_core.pc_reg);
    @(posedge clock);
    $display("test corners done");
    // zero, equal and sign-extended operands come up often on purpose
    repeat (300) begin
      r = $urandom; m = $urandom;
      a = r[1] ? (r[0] ? {{25{m[6]}}, m[6:0]} : 0) : $urandom;
      o = r[7:4] < 9 ? ops[8 * (8 - r[7:4]) +: 8] : r[15:8];
      issue(o, r[2], r[31:16], a, r[9] ? a : r, m);
      if (r[3]) begin
        issue_valid <= 0;
        @(posedge clock);
      end
    end
    issue_valid <= 0;
    repeat (5) @(posedge clock);
    $display("test random done");
    give_verdict;
  end
endmodule // tb_gic_exec
